/* p2pm_top.sv */
// Port 2 pin configuration mux: APB registers, pad control and level sampling
//
// Overview of operation
// - Drive field per pin; high bits at 3..0, low bits at 11..8; byte or word.
// - Direction bit 0 makes the field an output setting, 1 an input setting.
// - Output: 00 high-Z, 01 P-channel open drain, 10 N-channel open drain, 11 CMOS.
// - Input: 00 high-Z, 01 pull-down, 10 pull-up, 11 high-Z.
// - Drive configuration resets to zero, every pin high-Z output.
// - Active output drives the pin from the data bit.
// - Input pin level is returned as the port level.
// - Function field per pin n at bits n and n+8; byte or word; resets zero.
// - Pin 0 functions: GPIO, converter waveform in, serial data out, UART receive.
// - Pin 1 functions: GPIO, reference capacitor, serial data in, UART transmit.
// - Pin 2 functions: GPIO, reference resistor, serial clock, timer channel 2.
// - Pin 3 functions: GPIO, sensor resistor, serial select, timer channel 3.
// - Prohibited function on output pin ignores data; N-channel and CMOS force low.
// - Direction bit: 0 output (reset), 1 input.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
module p2pm_top
	import p2pm_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [p2pm_pkg::PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// Data and direction registers
	input wire logic [3:0] port_level_register_i,
	input wire logic [3:0] port_direction_i,
	// Peripheral pin functions, one entry per pin
	input wire p2pm_pkg::p2pm_alt_t [3:0] alt_i,
	// Pins
	input wire logic [3:0] pin_in_i,
	output p2pm_pkg::p2pm_pad_t pad_o,
	// Sampled levels to data register, function fields to peripherals
	output logic [3:0] port_level_o,
	output logic [3:0] func_field_lo_o,
	output logic [3:0] func_field_hi_o
);
	import p2pm_pkg::*;

	p2pm_state_t st_r;
	p2pm_state_t st_nxt;
	p2pm_pad_t pad_nxt;
	logic [3:0] prohib_nxt;
	logic [1:0] drv_fld [NPINS];
	logic [1:0] fn_fld [NPINS];
	logic acc_end;
	logic hit_drv;
	logic hit_fn;
	logic hit_stat;

	// ****************************************
	// Per-pin decode
	// ****************************************
	for (genvar n = 0; n < NPINS; n++)
	begin : g_pin
		assign drv_fld[n] = {st_r.drive_cfg[n], st_r.drive_cfg[n+FIELD_HI_OFS]};
		assign fn_fld[n] = {st_r.func_sel[n+FIELD_HI_OFS], st_r.func_sel[n]};
		// Function order per pin is fixed by how alt_i is wired up
		p2pm_pin_drive u_drive (
			.dir_i(port_direction_i[n]),
			.drive_i(drv_fld[n]),
			.func_i(fn_fld[n]),
			.data_i(port_level_register_i[n]),
			.alt_i(alt_i[n]),
			.out_o(pad_nxt.out[n]),
			.oe_o(pad_nxt.oe[n]),
			.pull_up_o(pad_nxt.pull_up[n]),
			.pull_down_o(pad_nxt.pull_down[n]),
			.prohib_o(prohib_nxt[n])
		);
	end

	// ****************************************
	// Register access and next state
	// ****************************************
	assign acc_end = psel && penable && st_r.pready;
	assign hit_drv = (paddr == ADDR_DRIVE_CFG);
	assign hit_fn = (paddr == ADDR_FUNC_SEL);
	assign hit_stat = (paddr == ADDR_STATUS);

	always_comb
	begin
		st_nxt = st_r;
		// One wait state keeps every bus output registered
		st_nxt.pready = psel && penable && !st_r.pready;
		st_nxt.pslverr = 1'b0;
		st_nxt.prdata = 32'h0000_0000;
		if (psel && penable && !st_r.pready)
		begin
			st_nxt.pslverr = !(hit_drv || hit_fn || hit_stat);
			if (hit_drv)
				st_nxt.prdata[15:0] = st_r.drive_cfg;
			else if (hit_fn)
				st_nxt.prdata[15:0] = st_r.func_sel;
			else if (hit_stat)
			begin
				st_nxt.prdata[STAT_LEVEL_POS +: NPINS] = st_r.level;
				st_nxt.prdata[STAT_PROHIB_POS +: NPINS] = st_r.prohib;
			end
		end
		if (acc_end && pwrite)
		begin
			// Byte lanes let software touch either half alone
			if (hit_drv && pstrb[0])
				st_nxt.drive_cfg[7:0] = pwdata[7:0];
			if (hit_drv && pstrb[1])
				st_nxt.drive_cfg[15:8] = pwdata[15:8];
			if (hit_fn && pstrb[0])
				st_nxt.func_sel[7:0] = pwdata[7:0];
			if (hit_fn && pstrb[1])
				st_nxt.func_sel[15:8] = pwdata[15:8];
		end
		st_nxt.pad = pad_nxt;
		st_nxt.prohib = prohib_nxt;
		// Input pins report the pin, output pins the data bit
		for (int i = 0; i < NPINS; i++)
			st_nxt.level[i] = port_direction_i[i] ? pin_in_i[i] : port_level_register_i[i];
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_r <= '0;
			st_r.drive_cfg <= DRIVE_CFG_RST;
			st_r.func_sel <= FUNC_SEL_RST;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign prdata = st_r.prdata;
	assign pad_o = st_r.pad;
	assign port_level_o = st_r.level;
	assign func_field_lo_o = st_r.func_sel[3:0];
	assign func_field_hi_o = st_r.func_sel[11:8];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	cfg_reset_zero_a: assert property ($past(rst_i) |-> st_r.drive_cfg == 16'h0000
		&& st_r.func_sel == 16'h0000 && pad_o.oe == 4'h0)
		else $error("Configuration not zero after reset");

	apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("APB answer not one wait state");

	drv_low_byte_a: assert property (acc_end && pwrite && hit_drv && pstrb[0] && !pstrb[1]
		|=> st_r.drive_cfg[7:0] == $past(pwdata[7:0]) && $stable(st_r.drive_cfg[15:8]))
		else $error("Drive byte write wrong");

	fn_word_write_a: assert property (acc_end && pwrite && hit_fn && pstrb[1:0] == 2'h3
		|=> st_r.func_sel == $past(pwdata[15:0]))
		else $error("Function word write wrong");

	cmos_drive_a: assert property (!port_direction_i[0] && fn_fld[0] == FN_GPIO
		&& drv_fld[0] == DRV_CMOS
		|=> pad_o.oe[0] && pad_o.out[0] == $past(port_level_register_i[0]))
		else $error("CMOS output does not follow data");

	nch_drive_a: assert property (!port_direction_i[1] && fn_fld[1] == FN_GPIO
		&& drv_fld[1] == DRV_NCH_OD
		|=> pad_o.oe[1] == !$past(port_level_register_i[1]) && !pad_o.out[1])
		else $error("N-channel open drain wrong");

	pch_drive_a: assert property (!port_direction_i[1] && fn_fld[1] == FN_GPIO
		&& drv_fld[1] == DRV_PCH_OD
		|=> pad_o.out[1] && pad_o.oe[1] == $past(port_level_register_i[1]))
		else $error("P-channel open drain wrong");

	input_pull_a: assert property (port_direction_i[2] && drv_fld[2] == IN_PULL_UP
		|=> pad_o.pull_up[2] && !pad_o.pull_down[2] && !pad_o.oe[2])
		else $error("Input pull-up wrong");

	pull_down_a: assert property (port_direction_i[1] && drv_fld[1] == IN_PULL_DOWN
		|=> pad_o.pull_down[1] && !pad_o.pull_up[1] && !pad_o.oe[1])
		else $error("Input pull-down wrong");

	input_no_drive_a: assert property (port_direction_i[0] |=> !pad_o.oe[0])
		else $error("Input pin driven");

	level_read_a: assert property (port_direction_i[3]
		|=> port_level_o[3] == $past(pin_in_i[3]))
		else $error("Input level not sampled");

	prohib_low_a: assert property (!port_direction_i[0] && fn_fld[0] != FN_GPIO
		&& !alt_i[0].avail[fn_fld[0] - 2'h1] && drv_fld[0] == DRV_CMOS
		|=> pad_o.oe[0] && !pad_o.out[0])
		else $error("Prohibited CMOS pin not low");

	prohib_hiz_a: assert property (!port_direction_i[1] && fn_fld[1] != FN_GPIO
		&& !alt_i[1].avail[fn_fld[1] - 2'h1] && drv_fld[1] == DRV_PCH_OD
		|=> !pad_o.oe[1])
		else $error("Prohibited P-channel pin driven");

	alt_route_a: assert property (!port_direction_i[1] && fn_fld[1] == 2'h3
		&& alt_i[1].avail[2] && alt_i[1].den[2] && drv_fld[1] == DRV_CMOS
		|=> pad_o.out[1] == $past(alt_i[1].dout[2]))
		else $error("Alternate output not routed");

	alt_disabled_a: assert property (!port_direction_i[3] && fn_fld[3] == 2'h3
		&& alt_i[3].avail[2] && !alt_i[3].den[2]
		|=> !pad_o.oe[3])
		else $error("Disabled alternate output driven");

	unmapped_err_a: assert property (psel && penable && !pready
		&& !(hit_drv || hit_fn || hit_stat)
		|=> pready && pslverr && prdata == 32'h0000_0000)
		else $error("Unmapped access not refused");
endmodule

/* p2pm_pkg.sv */
// Shared constants and types for the port 2 pin configuration mux
package p2pm_pkg;

	// ****************************************
	// Register map (index = printed offset)
	// ****************************************
	localparam int PADDR_W = 18;
	localparam logic [15:0] IDX_DRIVE_CFG = 16'hF222;
	localparam logic [15:0] IDX_FUNC_SEL = 16'hF224;
	localparam logic [15:0] IDX_STATUS = 16'hF226;
	localparam logic [PADDR_W-1:0] ADDR_DRIVE_CFG = {IDX_DRIVE_CFG, 2'h0};
	localparam logic [PADDR_W-1:0] ADDR_FUNC_SEL = {IDX_FUNC_SEL, 2'h0};
	localparam logic [PADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'h0};

	// ****************************************
	// Reset values and field positions
	// ****************************************
	localparam logic [15:0] DRIVE_CFG_RST = 16'h0000;
	localparam logic [15:0] FUNC_SEL_RST = 16'h0000;
	localparam int NPINS = 4;
	localparam int FIELD_HI_OFS = 8;
	localparam int STAT_LEVEL_POS = 0;
	localparam int STAT_PROHIB_POS = 8;

	// ****************************************
	// Field encodings
	// ****************************************
	localparam logic [1:0] DRV_HIZ = 2'h0;
	localparam logic [1:0] DRV_PCH_OD = 2'h1;
	localparam logic [1:0] DRV_NCH_OD = 2'h2;
	localparam logic [1:0] DRV_CMOS = 2'h3;
	localparam logic [1:0] IN_PULL_DOWN = 2'h1;
	localparam logic [1:0] IN_PULL_UP = 2'h2;
	localparam logic [1:0] FN_GPIO = 2'h0;
	localparam logic DIR_OUTPUT = 1'b0;

	// Alternate functions 1..3 of one pin, index = function code - 1
	typedef struct packed {
		logic [2:0] avail;
		logic [2:0] dout;
		logic [2:0] den;
	} p2pm_alt_t;

	// Pad controls of all pins
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
		logic [3:0] pull_up;
		logic [3:0] pull_down;
	} p2pm_pad_t;

	typedef struct packed {
		logic [15:0] drive_cfg;
		logic [15:0] func_sel;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		p2pm_pad_t pad;
		logic [3:0] level;
		logic [3:0] prohib;
	} p2pm_state_t;

endpackage

/* p2pm_pin_drive.sv */
// Per-pin pad control decode for the port 2 pin configuration mux
`timescale 1ns/100ps
module p2pm_pin_drive
	import p2pm_pkg::*;
(
	// Configuration
	input wire logic dir_i,
	input wire logic [1:0] drive_i,
	input wire logic [1:0] func_i,
	// Data sources
	input wire logic data_i,
	input wire p2pm_pkg::p2pm_alt_t alt_i,
	// Pad controls
	output logic out_o,
	output logic oe_o,
	output logic pull_up_o,
	output logic pull_down_o,
	output logic prohib_o
);
	logic alt_sel;
	logic [1:0] idx;
	logic val;
	logic en;

	always_comb
	begin
		alt_sel = (func_i != FN_GPIO);
		idx = func_i - 2'h1;
		val = alt_sel ? alt_i.dout[idx] : data_i;
		en = alt_sel ? alt_i.den[idx] : 1'b1;
		out_o = 1'b0;
		oe_o = 1'b0;
		pull_up_o = 1'b0;
		pull_down_o = 1'b0;
		prohib_o = 1'b0;
		if (dir_i == DIR_OUTPUT)
		begin
			if (alt_sel && !alt_i.avail[idx])
			begin
				// Data ignored; only N-channel and CMOS pull low
				prohib_o = 1'b1;
				oe_o = (drive_i == DRV_NCH_OD) || (drive_i == DRV_CMOS);
			end
			else if (en)
			begin
				case (drive_i)
					DRV_PCH_OD:
					begin
						out_o = 1'b1;
						oe_o = val;
					end
					DRV_NCH_OD:
					begin
						oe_o = !val;
					end
					DRV_CMOS:
					begin
						out_o = val;
						oe_o = 1'b1;
					end
					default:
					begin
						oe_o = 1'b0;
					end
				endcase
			end
		end
		else
		begin
			case (drive_i)
				IN_PULL_DOWN: pull_down_o = 1'b1;
				IN_PULL_UP: pull_up_o = 1'b1;
				default: pull_up_o = 1'b0;
			endcase
		end
	end
endmodule

/* p2pm_pin_model.sv */
// Partner model: pin loads and peripherals sharing port 2
`timescale 1ns/100ps
module p2pm_pin_model
	import p2pm_pkg::*;
(
	// Pad side
	input wire p2pm_pkg::p2pm_pad_t pad_i,
	input wire logic [3:0] ext_i,
	output logic [3:0] pin_o,
	// Peripheral side
	input wire logic [3:0] dout_i,
	input wire logic [3:0] den_i,
	input wire logic [2:0] avail_i,
	output p2pm_pkg::p2pm_alt_t [3:0] alt_o
);
	always_comb
	begin
		for (int n = 0; n < 4; n++)
		begin
			// Own drive wins over pulls, pulls over the far driver
			if (pad_i.oe[n])
				pin_o[n] = pad_i.out[n];
			else if (pad_i.pull_up[n] || pad_i.pull_down[n])
				pin_o[n] = pad_i.pull_up[n];
			else
				pin_o[n] = ext_i[n];
			alt_o[n].avail = avail_i;
			// Functions 2 and 3 give pin values that differ when dout_i bits differ, function 1 is always 1, so a wrong pick shows
			alt_o[n].dout = dout_i[n] ? 3'h5 : 3'h3;
			alt_o[n].den = {3{den_i[n]}};
		end
	end
endmodule

/* tb_p2pm_top.sv */
// Self-checking testbench for the port 2 pin configuration mux
`timescale 1ns/100ps
module tb_p2pm_top;
	import p2pm_pkg::*;
	logic clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [PADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] pstrb = 4'hF, lvl = 4'h0, dir = 4'h0, ext = 4'h9, pdo = 4'h5, pen = 4'hF, pin;
	logic [3:0] plev, flo, fhi, e;
	logic [15:0] f;
	logic [2:0] avail = 3'h7;
	p2pm_alt_t [3:0] alt;
	p2pm_pad_t pad;
	int error_cnt = 0, comparisons = 0, n;
	initial forever #50 clk_i = ~clk_i;
	p2pm_top u_p2pm_top (.clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .port_level_register_i(lvl),
		.port_direction_i(dir), .alt_i(alt), .pin_in_i(pin), .pad_o(pad),
		.port_level_o(plev), .func_field_lo_o(flo), .func_field_hi_o(fhi));
	p2pm_pin_model u_p2pm_pin_model (.pad_i(pad), .ext_i(ext), .pin_o(pin), .dout_i(pdo),
		.den_i(pen), .avail_i(avail), .alt_o(alt));
	task automatic test_done;
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; waits for pready without assuming a latency
	task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int k;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk_i);
		penable <= 1'b1;
		k = 0;
		// pready is read as it stood just before the edge that ends the access
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
		begin
			error_cnt++;
			$display("Error %0t: no pready", $time);
			test_done;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pads(input logic [3:0] oe, input logic [3:0] out, input logic [3:0] pu,
		input logic [3:0] pd);
		repeat (4) @(negedge clk_i);
		chk({pad.out & pad.oe, pad.oe, pad.pull_up, pad.pull_down}, {out, oe, pu, pd});
		@(posedge clk_i);
	endtask
	// ****
	// Tests
	// ****
	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		pads(4'h0, 4'h0, 4'h0, 4'h0);
		apb(1'b0, ADDR_DRIVE_CFG, 32'h0, 4'h0);
		chk(rd, DRIVE_CFG_RST);
		apb(1'b0, ADDR_FUNC_SEL, 32'h0, 4'h0);
		chk(rd, FUNC_SEL_RST);
		$display("reset test done");
		lvl <= 4'hF;
		apb(1'b1, ADDR_DRIVE_CFG, 32'h0A0C, 4'h3);
		pads(4'hA, 4'hA, 4'h0, 4'h0);
		lvl <= 4'h0;
		pads(4'hC, 4'h0, 4'h0, 4'h0);
		chk(plev, 4'h0);
		$display("output test done");
		dir <= 4'hF;
		pads(4'h0, 4'h0, 4'h4, 4'h2);
		chk(plev, 4'hD);
		ext <= 4'h6;
		pads(4'h0, 4'h0, 4'h4, 4'h2);
		chk(plev, 4'h4);
		$display("input test done");
		apb(1'b1, ADDR_DRIVE_CFG, 32'h0, 4'h2);
		apb(1'b0, ADDR_DRIVE_CFG, 32'h0, 4'h0);
		chk(rd, 32'h000C);
		apb(1'b1, ADDR_DRIVE_CFG, 32'h0302, 4'h1);
		apb(1'b0, ADDR_DRIVE_CFG, 32'h0, 4'h0);
		chk(rd, 32'h0002);
		dir <= 4'h0;
		pads(4'h2, 4'h0, 4'h0, 4'h0);
		$display("byte test done");
		apb(1'b1, ADDR_DRIVE_CFG, 32'h0F0F, 4'h3);
		for (int c = 1; c < 4; c++)
		begin
			f = {4'h0, {4{c[1]}}, 4'h0, {4{c[0]}}};
			apb(1'b1, ADDR_FUNC_SEL, {16'h0, f}, 4'h3);
			apb(1'b0, ADDR_FUNC_SEL, 32'h0, 4'h0);
			chk(rd, {16'h0, f});
			chk({fhi, flo}, {f[11:8], f[3:0]});
			for (n = 0; n < 4; n++)
				e[n] = pdo[n] ? c != 2 : c != 3;
			pads(4'hF, e, 4'h0, 4'h0);
		end
		pen <= 4'h5;
		pads(4'h5, 4'h5, 4'h0, 4'h0);
		pen <= 4'hF;
		$display("function test done");
		avail <= 3'h3;
		lvl <= 4'hF;
		apb(1'b1, ADDR_DRIVE_CFG, 32'h0A0C, 4'h3);
		pads(4'hC, 4'h0, 4'h0, 4'h0);
		apb(1'b0, ADDR_STATUS, 32'h0, 4'h0);
		chk(rd, 32'h0000_0F0F);
		chk(err, 1'b0);
		$display("prohibited test done");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		apb(1'b0, ADDR_DRIVE_CFG, 32'h0, 4'h0);
		chk(rd, DRIVE_CFG_RST);
		apb(1'b0, ADDR_FUNC_SEL, 32'h0, 4'h0);
		chk(rd, FUNC_SEL_RST);
		pads(4'h0, 4'h0, 4'h0, 4'h0);
		$display("mid-run reset test done");
		dir <= 4'hF;
		apb(1'b1, ADDR_FUNC_SEL, 32'h000F, 4'h3);
		pads(4'h0, 4'h0, 4'h0, 4'h0);
		chk(plev, 4'h6);
		dir <= 4'h0;
		pads(4'h0, 4'h0, 4'h0, 4'h0);
		$display("converter test done");
		apb(1'b0, ADDR_STATUS + 18'h8, 32'h0, 4'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		$display("unmapped test done");
		test_done;
	end
endmodule
